// >>> rtl/kr7_pkg.sv
package kr7_pkg;
   typedef enum logic [1:0] {
      KR7_FN_GPIO,
      KR7_FN_ROW_SENSE,
      KR7_FN_CODEC_CLK
   } kr7_fn_t;
   localparam kr7_fn_t KR7_FN_RESET = KR7_FN_GPIO;
   localparam logic KR7_GPIO_DIR_RESET = 1'h0;
   localparam logic KR7_GPIO_VAL_RESET = 1'h0;
   localparam logic KR7_SYNC_MODE_RESET = 1'h1;
   localparam logic KR7_CODEC_DRIVE_RESET = 1'h0;
   localparam logic KR7_ROW_IDLE = 1'h1;
   localparam logic KR7_CLK_IDLE = 1'h0;
   localparam logic KR7_TCK_IDLE = 1'h1;
   localparam int KR7_SYNC_STAGES = 2;
   localparam int KR7_SYNC_WIDTH = 4;
endpackage : kr7_pkg

// >>> rtl/kr7_sync.sv
`timescale 1ns/1ps
`default_nettype none
module kr7_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_q;

   if (WIDTH < 1) begin : g_bad_width
      $error("kr7_sync needs WIDTH of at least one");
   end

   // The first stage feeds only the second stage.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         meta_q <= '0;
         sync_out <= '0;
      end else begin
         meta_q <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule : kr7_sync
`default_nettype wire

// >>> rtl/kr7_pin_mux.sv
`timescale 1ns/1ps
`default_nettype none
module kr7_pin_mux
   import kr7_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic pin_mux_select,
   input wire logic pin_in,
   output logic pin_out,
   output logic pin_oe,
   output logic pull_en,
   input wire logic primary_tck_pin,
   input wire logic primary_sck_pin,
   input wire logic cfg_load,
   input wire kr7_fn_t cfg_function,
   input wire logic cfg_gpio_output,
   input wire logic ring_indicator_out,
   input wire logic cfg_codec_sync_mode,
   input wire logic cfg_codec_clock_drive,
   input wire logic codec_clock_generated,
   output logic tap_tck,
   output logic primary_tck_connected,
   output logic keypad_row_sense_7,
   output logic general_input_default,
   output logic codec_tx_clock,
   output logic codec_rx_clock,
   output logic primary_sck_enabled,
   output kr7_fn_t function_active
);
   logic [KR7_SYNC_WIDTH-1:0] raw_w;
   logic [KR7_SYNC_WIDTH-1:0] sync_w;
   logic sel_s;
   logic pin_s;
   logic ptck_s;
   logic psck_s;
   logic gpio_dir_q;
   logic gpio_val_q;
   logic sync_mode_q;
   logic codec_drive_q;
   logic normal_w;
   logic alt_codec_w;
   logic drive_w;
   logic codec_clk_w;

   assign raw_w = {pin_mux_select, pin_in, primary_tck_pin, primary_sck_pin};

   // Pins and the select come from outside, so all pass two flops first.
   kr7_sync #(
      .WIDTH(KR7_SYNC_WIDTH)
   ) u_sync (
      .clk(clk),
      .rstn(rstn),
      .async_in(raw_w),
      .sync_out(sync_w)
   );

   assign sel_s = sync_w[3];
   assign pin_s = sync_w[2];
   assign ptck_s = sync_w[1];
   assign psck_s = sync_w[0];

   // The slices above assume four synchronised signals through a two-flop chain.
   if (KR7_SYNC_WIDTH != 4 || KR7_SYNC_STAGES != 2) begin : g_bad_sync
      $error("kr7_pin_mux needs four synchronised signals through two flops");
   end

   // Configuration is held here so the pin stays an input until software loads a new one.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         function_active <= KR7_FN_RESET;
         gpio_dir_q <= KR7_GPIO_DIR_RESET;
         gpio_val_q <= KR7_GPIO_VAL_RESET;
         sync_mode_q <= KR7_SYNC_MODE_RESET;
         codec_drive_q <= KR7_CODEC_DRIVE_RESET;
      end else if (cfg_load) begin
         function_active <= cfg_function;
         gpio_dir_q <= cfg_gpio_output;
         gpio_val_q <= ring_indicator_out;
         sync_mode_q <= cfg_codec_sync_mode;
         codec_drive_q <= cfg_codec_clock_drive;
      end
   end

   assign normal_w = !sel_s;
   assign alt_codec_w = normal_w && (function_active == KR7_FN_CODEC_CLK);
   assign drive_w = normal_w && (((function_active == KR7_FN_GPIO) && gpio_dir_q) ||
                                 (alt_codec_w && codec_drive_q));
   // When the codec is master the pin itself is not read back, which avoids a sampled loop.
   assign codec_clk_w = codec_drive_q ? codec_clock_generated : pin_s;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pin_out <= 1'h0;
         pin_oe <= 1'h0;
         pull_en <= 1'h1;
      end else begin
         pin_oe <= drive_w;
         pin_out <= drive_w && ((function_active == KR7_FN_GPIO) ? gpio_val_q : codec_clock_generated);
         pull_en <= !drive_w;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         tap_tck <= KR7_TCK_IDLE;
         primary_tck_connected <= 1'h1;
      end else begin
         tap_tck <= sel_s ? pin_s : ptck_s;
         primary_tck_connected <= normal_w;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         keypad_row_sense_7 <= KR7_ROW_IDLE;
         general_input_default <= 1'h0;
      end else begin
         keypad_row_sense_7 <= (normal_w && function_active == KR7_FN_ROW_SENSE) ? pin_s : KR7_ROW_IDLE;
         general_input_default <= (normal_w && function_active == KR7_FN_GPIO && !gpio_dir_q) ? pin_s : 1'h0;
      end
   end

   // Sampling at the system clock limits the usable codec and test clock rate to well below 12.5 MHz.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         codec_tx_clock <= KR7_CLK_IDLE;
         codec_rx_clock <= KR7_CLK_IDLE;
         primary_sck_enabled <= 1'h1;
      end else begin
         primary_sck_enabled <= !alt_codec_w;
         if (alt_codec_w) begin
            codec_tx_clock <= codec_clk_w;
            codec_rx_clock <= sync_mode_q ? codec_clk_w : KR7_CLK_IDLE;
         end else begin
            codec_tx_clock <= psck_s;
            codec_rx_clock <= psck_s;
         end
      end
   end

   property p_tck_alt;
      @(posedge clk) disable iff (!rstn) sel_s |=> (tap_tck == $past(pin_s) && !primary_tck_connected);
   endproperty
   a_tck_alt: assert property (p_tck_alt) else $error("alternate test clock not routed");

   property p_tck_primary_cut;
      @(posedge clk) disable iff (!rstn) (sel_s && (pin_s != ptck_s)) |=> tap_tck != $past(ptck_s);
   endproperty
   a_tck_primary_cut: assert property (p_tck_primary_cut) else $error("primary test clock leaks");

   // With the select low the dedicated pin must reach the test logic again.
   property p_tck_primary;
      @(posedge clk) disable iff (!rstn) !sel_s |=> tap_tck == $past(ptck_s);
   endproperty
   a_tck_primary: assert property (p_tck_primary) else $error("dedicated test clock not routed");

   property p_row_sense;
      @(posedge clk) disable iff (!rstn)
         (normal_w && function_active == KR7_FN_ROW_SENSE) |=> keypad_row_sense_7 == $past(pin_s);
   endproperty
   a_row_sense: assert property (p_row_sense) else $error("row sense not following pin");

   property p_codec_sync;
      @(posedge clk) disable iff (!rstn) (alt_codec_w && sync_mode_q) |=> codec_rx_clock == codec_tx_clock;
   endproperty
   a_codec_sync: assert property (p_codec_sync) else $error("sync mode clocks differ");

   property p_codec_async;
      @(posedge clk) disable iff (!rstn)
         (alt_codec_w && !sync_mode_q) |=> (codec_rx_clock == KR7_CLK_IDLE && codec_tx_clock == $past(codec_clk_w));
   endproperty
   a_codec_async: assert property (p_codec_async) else $error("async mode receiver clocked");

   property p_codec_primary;
      @(posedge clk) disable iff (!rstn)
         !alt_codec_w |=> (codec_tx_clock == $past(psck_s) && codec_rx_clock == $past(psck_s));
   endproperty
   a_codec_primary: assert property (p_codec_primary) else $error("pin leaks into codec clocks");

   property p_primary_sck_off;
      @(posedge clk) disable iff (!rstn) alt_codec_w |=> !primary_sck_enabled;
   endproperty
   a_primary_sck_off: assert property (p_primary_sck_off) else $error("primary codec clock still enabled");

   property p_ring_out;
      @(posedge clk) disable iff (!rstn)
         (normal_w && function_active == KR7_FN_GPIO && gpio_dir_q) |=> (pin_oe && pin_out == $past(gpio_val_q));
   endproperty
   a_ring_out: assert property (p_ring_out) else $error("ring indicator not driven");

   property p_hold_input;
      @(posedge clk) disable iff (!rstn)
         (function_active == KR7_FN_GPIO && !gpio_dir_q && !cfg_load) |=>
            (function_active == KR7_FN_GPIO && !gpio_dir_q);
   endproperty
   a_hold_input: assert property (p_hold_input) else $error("input default lost without a load");

   property p_pull_off;
      @(posedge clk) disable iff (!rstn) pull_en != pin_oe;
   endproperty
   a_pull_off: assert property (p_pull_off) else $error("pull resistor attached while driving");

   property p_inactive;
      @(posedge clk) disable iff (!rstn)
         sel_s |=> (keypad_row_sense_7 == KR7_ROW_IDLE && !general_input_default && !pin_oe);
   endproperty
   a_inactive: assert property (p_inactive) else $error("unselected input not idle");

   c_alt_tck: cover property (@(posedge clk) disable iff (!rstn) sel_s ##1 $rose(tap_tck));
   c_codec_master: cover property (@(posedge clk) disable iff (!rstn) alt_codec_w && codec_drive_q ##1 pin_oe);
   c_row_press: cover property (@(posedge clk) disable iff (!rstn) $fell(keypad_row_sense_7));
   c_ring: cover property (@(posedge clk) disable iff (!rstn) $rose(pin_out) && function_active == KR7_FN_GPIO);
   c_gpio_input: cover property (@(posedge clk) disable iff (!rstn) $rose(general_input_default));
endmodule : kr7_pin_mux
`default_nettype wire

// >>> verif/kr7_pad_model.sv
`timescale 1ns/1ps
`default_nettype none
module kr7_pad_model (
   input wire logic clk,
   input wire logic pin_out,
   input wire logic pin_oe,
   input wire logic pull_en,
   input wire logic ext_en,
   input wire logic ext_val,
   output var logic pin_in
);
   logic toggle_q = 1'h0;
   always_ff @(posedge clk) begin
      toggle_q <= ~toggle_q;
   end
   // A pad nobody drives and nothing pulls has no defined level, so it wanders.
   always_comb begin
      if (pin_oe) begin
         pin_in = pin_out;
      end else if (ext_en) begin
         pin_in = ext_val;
      end else if (pull_en) begin
         pin_in = 1'h1;
      end else begin
         pin_in = toggle_q;
      end
   end
endmodule : kr7_pad_model
`default_nettype wire

// >>> verif/keypad_keypad_row_sense_7_pin_mux_test.sv
`timescale 1ns/1ps
`default_nettype none
module keypad_keypad_row_sense_7_pin_mux_test;
   import kr7_pkg::*;
   logic clk = 1'h0;
   logic rstn, sel, pin_in, pin_out, pin_oe, pull_en, tck_p, sck_p, cfg_load, gpo, ring, sync_m, drv, gen;
   logic tap_tck, tck_conn, row, gin, txc, rxc, sck_en, ext_en, ext_val;
   kr7_fn_t fn, fn_act;
   int fail_count = 0;
   int total_checks = 0;
   always #20 clk = ~clk;
   kr7_pin_mux DUT (.clk(clk), .rstn(rstn), .pin_mux_select(sel), .pin_in(pin_in), .pin_out(pin_out),
      .pin_oe(pin_oe), .pull_en(pull_en), .primary_tck_pin(tck_p), .primary_sck_pin(sck_p),
      .cfg_load(cfg_load), .cfg_function(fn), .cfg_gpio_output(gpo), .ring_indicator_out(ring),
      .cfg_codec_sync_mode(sync_m), .cfg_codec_clock_drive(drv), .codec_clock_generated(gen),
      .tap_tck(tap_tck), .primary_tck_connected(tck_conn), .keypad_row_sense_7(row),
      .general_input_default(gin), .codec_tx_clock(txc), .codec_rx_clock(rxc),
      .primary_sck_enabled(sck_en), .function_active(fn_act));
   kr7_pad_model u_pad (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe), .pull_en(pull_en),
      .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));
   task automatic chk(input string name, input logic [1:0] seen, input logic [1:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk
   // Four edges covers the three-edge sync and output path with margin.
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : step
   task automatic load(input kr7_fn_t f, input logic o, input logic r, input logic s, input logic d);
      @(posedge clk);
      cfg_load <= 1'h1;
      fn <= f;
      gpo <= o;
      ring <= r;
      sync_m <= s;
      drv <= d;
      @(posedge clk);
      cfg_load <= 1'h0;
      step(4);
   endtask : load
   task automatic pad(input logic v);
      @(posedge clk);
      ext_val <= v;
      step(4);
   endtask : pad
   task automatic t_reset();
      chk("fn", fn_act, KR7_FN_GPIO);
      chk("oe", pin_oe, 1'h0);
      chk("pull", pull_en, 1'h1);
      chk("row", row, 1'h1);
      pad(1'h1);
      chk("gin", gin, 1'h1);
      pad(1'h0);
      chk("gin", gin, 1'h0);
      chk("tck", tap_tck, 1'h0);
      chk("tconn", tck_conn, 1'h1);
   endtask : t_reset
   task automatic t_gpio_out();
      load(KR7_FN_GPIO, 1'h1, 1'h1, 1'h1, 1'h0);
      chk("oe", pin_oe, 1'h1);
      chk("out", pin_out, 1'h1);
      chk("pull", pull_en, 1'h0);
      load(KR7_FN_GPIO, 1'h1, 1'h0, 1'h1, 1'h0);
      chk("out", pin_out, 1'h0);
   endtask : t_gpio_out
   task automatic t_row();
      load(KR7_FN_ROW_SENSE, 1'h0, 1'h0, 1'h1, 1'h0);
      chk("pull", pull_en, 1'h1);
      chk("row", row, 1'h0);
      chk("gin", gin, 1'h0);
      pad(1'h1);
      chk("row", row, 1'h1);
      @(posedge clk);
      sck_p <= 1'h1;
      step(4);
      chk("tx", txc, 1'h1);
      chk("rx", rxc, 1'h1);
      chk("psck", sck_en, 1'h1);
      @(posedge clk);
      sck_p <= 1'h0;
   endtask : t_row
   task automatic t_codec(input logic s);
      load(KR7_FN_CODEC_CLK, 1'h0, 1'h0, s, 1'h0);
      chk("tx", txc, 1'h1);
      chk("rx", rxc, s);
      chk("psck", sck_en, 1'h0);
      chk("row", row, 1'h1);
   endtask : t_codec
   task automatic t_codec_master();
      @(posedge clk);
      gen <= 1'h1;
      load(KR7_FN_CODEC_CLK, 1'h0, 1'h0, 1'h1, 1'h1);
      chk("oe", pin_oe, 1'h1);
      chk("pull", pull_en, 1'h0);
      chk("tx", txc, 1'h1);
      @(posedge clk);
      gen <= 1'h0;
      step(2);
      chk("out", pin_out, 1'h0);
   endtask : t_codec_master
   task automatic t_select();
      load(KR7_FN_GPIO, 1'h1, 1'h1, 1'h1, 1'h0);
      @(posedge clk);
      sel <= 1'h1;
      tck_p <= 1'h1;
      // The pad is only released once the select has crossed, so settle that before moving the pad.
      step(4);
      chk("oe", pin_oe, 1'h0);
      chk("tconn", tck_conn, 1'h0);
      pad(1'h0);
      chk("tck", tap_tck, 1'h0);
      pad(1'h1);
      chk("tck", tap_tck, 1'h1);
      @(posedge clk);
      sel <= 1'h0;
      ext_val <= 1'h0;
      step(4);
      chk("tconn", tck_conn, 1'h1);
      chk("tck", tap_tck, 1'h1);
   endtask : t_select
   task automatic finish_test();
      if (fail_count == 0 && total_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : finish_test
   initial begin
      #50us;
      fail_count++;
      finish_test();
   end
   initial begin
      {rstn, sel, tck_p, sck_p, cfg_load, gpo, ring, sync_m, drv, gen, ext_val} = '0;
      fn = KR7_FN_GPIO;
      ext_en = 1'h1;
      repeat (5) @(posedge clk);
      rstn <= 1'h1;
      step(1);
      t_reset();
      t_gpio_out();
      t_row();
      t_codec(1'h1);
      t_codec(1'h0);
      t_codec_master();
      t_select();
      finish_test();
   end
endmodule : keypad_keypad_row_sense_7_pin_mux_test
`default_nettype wire
